// ---- hdl/bcbs_branch_cond.sv ----
// branch condition table for the 2x opcode family
`timescale 1ns/1ps
module bcbs_branch_cond (
	// opcode low nibble and flags
	input  wire logic [3:0] i_cond,
	input  wire logic [3:0] i_flags,
	// decision
	output logic            o_taken
);
	logic n, z, v, c;

	always_comb
	begin
		n = i_flags[bcbs_pkg::FLAG_N];
		z = i_flags[bcbs_pkg::FLAG_Z];
		v = i_flags[bcbs_pkg::FLAG_V];
		c = i_flags[bcbs_pkg::FLAG_C];
		case (i_cond)
			4'h0: o_taken = 1'b1;
			4'h1: o_taken = 1'b0;
			4'h2: o_taken = ~(c | z);
			4'h3: o_taken = c | z;
			4'h4: o_taken = ~c;
			4'h5: o_taken = c;
			4'h6: o_taken = ~z;
			4'h7: o_taken = z;
			4'h8: o_taken = ~v;
			4'h9: o_taken = v;
			4'hA: o_taken = ~n;
			4'hB: o_taken = n;
			4'hC: o_taken = ~(n ^ v);
			4'hD: o_taken = n ^ v;
			4'hE: o_taken = ~(z | (n ^ v));
			4'hF: o_taken = z | (n ^ v);
			default: o_taken = 1'b0;
		endcase
	end
endmodule

// ---- hdl/bcbs_eclk_div.sv ----
// e-clock enable divider: one-cycle tick every DIV core clocks
`timescale 1ns/1ps
module bcbs_eclk_div #(
	parameter int DIV = bcbs_pkg::E_DIV_DEFAULT
) (
	// clock and reset
	input  wire logic i_core_clk,
	input  wire logic i_sys_rst,
	// enable out
	output logic      o_tick
);
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;

	always_comb
	begin
		cnt_next = (cnt_reg == 8'(DIV - 1)) ? 8'h00 : cnt_reg + 8'h01;
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_sys_rst)
		begin
			cnt_reg <= 8'h00;
			o_tick  <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			o_tick  <= (cnt_reg == 8'(DIV - 1));
		end
	end
endmodule

// ---- hdl/bcbs_pkg.sv ----
// constants, types and carriers of the bit-set / call / branch sequencer
// Summary of operation
// - set-bits opcodes 14, 1C, 18 1C; 6/7/8 cycles
// - address, operand, mask, dummy FFFF, write back
// - call first advances pc by two
// - push return low byte, then stack pointer minus one
// - push return high byte, then stack pointer minus one
// - then pc becomes advanced pc plus offset
// - call 8D: six cycles in fixed order
// - opcode 28 branches when overflow is clear
// - no-overflow branch: opcode, offset, dummy FFFF
// - signed greater, less-equal, greater-equal, less conditions
// - equal, not-equal, minus, plus, overflow, always, never
package bcbs_pkg;

	// ****************************************
	// opcodes
	// ****************************************
	localparam logic [7:0] OP_SET_BITS_DIR  = 8'h14;
	localparam logic [7:0] OP_SET_BITS_IDX  = 8'h1C;
	localparam logic [7:0] OP_PREFIX_Y      = 8'h18;
	localparam logic [7:0] OP_REL_CALL      = 8'h8D;
	localparam logic [3:0] OP_BRANCH_HI     = 4'h2;
	localparam logic [7:0] OP_BR_NO_OVF     = 8'h28;

	// ****************************************
	// bus and reset values
	// ****************************************
	localparam logic [15:0] DUMMY_ADDR      = 16'hFFFF;
	localparam logic [15:0] PC_STEP         = 16'h0001;
	localparam logic [15:0] SP_STEP         = 16'h0001;
	localparam logic [15:0] PC_RESET        = 16'h0000;
	localparam logic [15:0] SP_RESET        = 16'h00FF;
	localparam int          E_DIV_DEFAULT   = 4;

	// ****************************************
	// condition code bit positions
	// ****************************************
	localparam int FLAG_C = 0;
	localparam int FLAG_V = 1;
	localparam int FLAG_Z = 2;
	localparam int FLAG_N = 3;

	// ****************************************
	// apb register map and fields
	// ****************************************
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_FLAGS  = 8'h04;
	localparam logic [7:0] REG_PC     = 8'h08;
	localparam logic [7:0] REG_SP     = 8'h0C;
	localparam logic [7:0] REG_IX     = 8'h10;
	localparam logic [7:0] REG_IY     = 8'h14;
	localparam logic [7:0] REG_STATUS = 8'h18;
	localparam int CTRL_RUN    = 0;
	localparam int STAT_BUSY   = 0;
	localparam int STAT_TAKEN  = 1;
	localparam int STAT_BADOP  = 2;
	localparam int STAT_OP_LSB = 8;

	typedef enum logic [3:0] {
		S_FETCH, S_PREFIX, S_OFFSET, S_IDX_DUMMY, S_OPER, S_MASK, S_MASK_DUMMY,
		S_WRITE, S_BR_DUMMY, S_CALL_DUMMY, S_CALL_SUB, S_PUSH_LO, S_PUSH_HI
	} bcbs_state_t;

	typedef enum logic [1:0] {M_DIR, M_IDX_X, M_IDX_Y} bcbs_mode_t;

	typedef struct packed {
		logic        valid;
		logic        rw;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} bcbs_bus_t;

endpackage

// ---- hdl/bcbs_sequencer.sv ----
// bit-set, relative call and conditional branch sequencer with apb control
`timescale 1ns/1ps
module bcbs_sequencer #(
	parameter int E_DIV = bcbs_pkg::E_DIV_DEFAULT
) (
	// clock and reset
	input  wire logic                    i_core_clk,
	input  wire logic                    i_sys_rst,
	// apb slave
	input  wire logic                    i_psel,
	input  wire logic                    i_penable,
	input  wire logic                    i_pwrite,
	input  wire logic [7:0]              i_paddr,
	input  wire logic [31:0]             i_pwdata,
	output logic      [31:0]             o_prdata,
	output logic                         o_pready,
	output logic                         o_pslverr,
	// system bus, one access per e-cycle
	output bcbs_pkg::bcbs_bus_t          o_bus,
	input  wire logic [7:0]              i_bus_rdata,
	output logic                         o_e_tick
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		bcbs_pkg::bcbs_state_t st;
		bcbs_pkg::bcbs_mode_t  mode;
		logic [7:0]            opcode;
		logic [15:0]           pc;
		logic [15:0]           sp;
		logic [15:0]           ix;
		logic [15:0]           iy;
		logic [15:0]           op_addr;
		logic [15:0]           ea;
		logic [15:0]           tgt;
		logic [7:0]            off;
		logic [7:0]            oper;
		logic [7:0]            mask;
		logic [3:0]            cyc;
		logic [3:0]            flags;
		logic                  run;
		logic                  taken;
		logic                  bad_op;
		bcbs_pkg::bcbs_bus_t   bus;
		logic [31:0]           prdata;
		logic                  pready;
		logic                  pslverr;
	} bcbs_core_t;

	bcbs_core_t core_reg;
	bcbs_core_t core_next;
	logic       e_tick;
	logic       cond_taken;

	bcbs_eclk_div #(
		.DIV        (E_DIV)
	) u_div (
		.i_core_clk (i_core_clk),
		.i_sys_rst  (i_sys_rst),
		.o_tick     (e_tick)
	);

	bcbs_branch_cond u_cond (
		.i_cond  (core_reg.opcode[3:0]),
		.i_flags (core_reg.flags),
		.o_taken (cond_taken)
	);

	function automatic logic [15:0] sext(input logic [7:0] b);
		sext = {{8{b[7]}}, b};
	endfunction

	// ****************************************
	// next state
	// ****************************************
	always_comb
	begin
		logic idle;
		logic [15:0] base;
		idle      = 1'b0;
		base      = 16'h0000;
		core_next = core_reg;

		if (e_tick)
		begin
			case (core_reg.st)
				bcbs_pkg::S_FETCH:
				begin
					if (core_reg.run)
					begin
						core_next.opcode  = i_bus_rdata;
						core_next.op_addr = core_reg.pc;
						core_next.pc      = core_reg.pc + bcbs_pkg::PC_STEP;
						core_next.bad_op  = 1'b0;
						core_next.taken   = 1'b0;
						if (i_bus_rdata == bcbs_pkg::OP_SET_BITS_DIR)
						begin
							core_next.mode = bcbs_pkg::M_DIR;
							core_next.st   = bcbs_pkg::S_OFFSET;
						end
						else if (i_bus_rdata == bcbs_pkg::OP_SET_BITS_IDX)
						begin
							core_next.mode = bcbs_pkg::M_IDX_X;
							core_next.st   = bcbs_pkg::S_OFFSET;
						end
						else if (i_bus_rdata == bcbs_pkg::OP_PREFIX_Y)
						begin
							core_next.st = bcbs_pkg::S_PREFIX;
						end
						else if (i_bus_rdata == bcbs_pkg::OP_REL_CALL ||
							i_bus_rdata[7:4] == bcbs_pkg::OP_BRANCH_HI)
						begin
							core_next.st = bcbs_pkg::S_OFFSET;
						end
						else
						begin
							// other opcodes belong elsewhere; flag and move on
							core_next.bad_op = 1'b1;
						end
					end
				end
				bcbs_pkg::S_PREFIX:
				begin
					core_next.pc = core_reg.pc + bcbs_pkg::PC_STEP;
					if (i_bus_rdata == bcbs_pkg::OP_SET_BITS_IDX)
					begin
						core_next.opcode = i_bus_rdata;
						core_next.mode   = bcbs_pkg::M_IDX_Y;
						core_next.st     = bcbs_pkg::S_OFFSET;
					end
					else
					begin
						core_next.bad_op = 1'b1;
						core_next.st     = bcbs_pkg::S_FETCH;
					end
				end
				bcbs_pkg::S_OFFSET:
				begin
					core_next.off = i_bus_rdata;
					core_next.pc  = core_reg.pc + bcbs_pkg::PC_STEP;
					base = (core_reg.mode == bcbs_pkg::M_IDX_Y) ? core_reg.iy : core_reg.ix;
					if (core_reg.opcode == bcbs_pkg::OP_SET_BITS_DIR)
					begin
						core_next.ea = {8'h00, i_bus_rdata};
						core_next.st = bcbs_pkg::S_OPER;
					end
					else if (core_reg.opcode == bcbs_pkg::OP_SET_BITS_IDX)
					begin
						core_next.ea = base + {8'h00, i_bus_rdata};
						core_next.st = bcbs_pkg::S_IDX_DUMMY;
					end
					else if (core_reg.opcode == bcbs_pkg::OP_REL_CALL)
					begin
						core_next.st = bcbs_pkg::S_CALL_DUMMY;
					end
					else
					begin
						core_next.st = bcbs_pkg::S_BR_DUMMY;
					end
				end
				bcbs_pkg::S_IDX_DUMMY:
				begin
					core_next.st = bcbs_pkg::S_OPER;
				end
				bcbs_pkg::S_OPER:
				begin
					core_next.oper = i_bus_rdata;
					core_next.st   = bcbs_pkg::S_MASK;
				end
				bcbs_pkg::S_MASK:
				begin
					core_next.mask = i_bus_rdata;
					core_next.pc   = core_reg.pc + bcbs_pkg::PC_STEP;
					core_next.st   = bcbs_pkg::S_MASK_DUMMY;
				end
				bcbs_pkg::S_MASK_DUMMY:
				begin
					core_next.st = bcbs_pkg::S_WRITE;
				end
				bcbs_pkg::S_WRITE:
				begin
					core_next.st = bcbs_pkg::S_FETCH;
				end
				bcbs_pkg::S_BR_DUMMY:
				begin
					// decision taken in the dummy cycle, flags are stable here
					core_next.taken = cond_taken;
					if (cond_taken)
					begin
						core_next.pc = core_reg.pc + sext(core_reg.off);
					end
					core_next.st = bcbs_pkg::S_FETCH;
				end
				bcbs_pkg::S_CALL_DUMMY:
				begin
					core_next.tgt = core_reg.pc + sext(core_reg.off);
					core_next.st  = bcbs_pkg::S_CALL_SUB;
				end
				bcbs_pkg::S_CALL_SUB:
				begin
					core_next.st = bcbs_pkg::S_PUSH_LO;
				end
				bcbs_pkg::S_PUSH_LO:
				begin
					core_next.sp = core_reg.sp - bcbs_pkg::SP_STEP;
					core_next.st = bcbs_pkg::S_PUSH_HI;
				end
				bcbs_pkg::S_PUSH_HI:
				begin
					core_next.sp    = core_reg.sp - bcbs_pkg::SP_STEP;
					core_next.pc    = core_reg.tgt;
					core_next.taken = 1'b1;
					core_next.st    = bcbs_pkg::S_FETCH;
				end
				default:
				begin
					core_next.st = bcbs_pkg::S_FETCH;
				end
			endcase
			core_next.cyc = (core_next.st == bcbs_pkg::S_FETCH) ? 4'h0 : core_reg.cyc + 4'h1;
		end

		// ****************************************
		// apb slave: one wait-free access phase
		// ****************************************
		idle = (core_reg.st == bcbs_pkg::S_FETCH) && !core_reg.run;
		core_next.pready  = i_psel && !i_penable;
		core_next.pslverr = 1'b0;
		core_next.prdata  = 32'h0000_0000;
		if (i_psel && !i_penable)
		begin
			case (i_paddr)
				bcbs_pkg::REG_CTRL:   core_next.prdata[bcbs_pkg::CTRL_RUN] = core_reg.run;
				bcbs_pkg::REG_FLAGS:  core_next.prdata[3:0] = core_reg.flags;
				bcbs_pkg::REG_PC:     core_next.prdata[15:0] = core_reg.pc;
				bcbs_pkg::REG_SP:     core_next.prdata[15:0] = core_reg.sp;
				bcbs_pkg::REG_IX:     core_next.prdata[15:0] = core_reg.ix;
				bcbs_pkg::REG_IY:     core_next.prdata[15:0] = core_reg.iy;
				bcbs_pkg::REG_STATUS:
				begin
					core_next.prdata[bcbs_pkg::STAT_BUSY]  = core_reg.st != bcbs_pkg::S_FETCH;
					core_next.prdata[bcbs_pkg::STAT_TAKEN] = core_reg.taken;
					core_next.prdata[bcbs_pkg::STAT_BADOP] = core_reg.bad_op;
					core_next.prdata[bcbs_pkg::STAT_OP_LSB +: 8] = core_reg.opcode;
				end
				default:              core_next.pslverr = 1'b1;
			endcase
		end
		if (i_psel && i_penable && core_reg.pready && i_pwrite)
		begin
			// programmer-model writes only land while the core is stopped
			case (i_paddr)
				bcbs_pkg::REG_CTRL: core_next.run = i_pwdata[bcbs_pkg::CTRL_RUN];
				bcbs_pkg::REG_FLAGS: if (idle) core_next.flags = i_pwdata[3:0];
				bcbs_pkg::REG_PC:   if (idle) core_next.pc = i_pwdata[15:0];
				bcbs_pkg::REG_SP:   if (idle) core_next.sp = i_pwdata[15:0];
				bcbs_pkg::REG_IX:   if (idle) core_next.ix = i_pwdata[15:0];
				bcbs_pkg::REG_IY:   if (idle) core_next.iy = i_pwdata[15:0];
				default:            core_next.run = core_reg.run;
			endcase
		end

		// ****************************************
		// bus cycle for the next e-cycle
		// ****************************************
		core_next.bus.valid = (core_next.st != bcbs_pkg::S_FETCH) || core_next.run;
		core_next.bus.rw    = 1'b1;
		core_next.bus.wdata = 8'h00;
		case (core_next.st)
			bcbs_pkg::S_OPER:      core_next.bus.addr = core_next.ea;
			bcbs_pkg::S_WRITE:
			begin
				core_next.bus.addr  = core_next.ea;
				core_next.bus.rw    = 1'b0;
				core_next.bus.wdata = core_next.oper | core_next.mask;
			end
			bcbs_pkg::S_IDX_DUMMY, bcbs_pkg::S_MASK_DUMMY, bcbs_pkg::S_BR_DUMMY,
			bcbs_pkg::S_CALL_DUMMY: core_next.bus.addr = bcbs_pkg::DUMMY_ADDR;
			bcbs_pkg::S_CALL_SUB:   core_next.bus.addr = core_next.tgt;
			bcbs_pkg::S_PUSH_LO:
			begin
				core_next.bus.addr  = core_next.sp;
				core_next.bus.rw    = 1'b0;
				core_next.bus.wdata = core_next.pc[7:0];
			end
			bcbs_pkg::S_PUSH_HI:
			begin
				core_next.bus.addr  = core_next.sp;
				core_next.bus.rw    = 1'b0;
				core_next.bus.wdata = core_next.pc[15:8];
			end
			default:               core_next.bus.addr = core_next.pc;
		endcase
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_sys_rst)
		begin
			core_reg           <= '0;
			core_reg.st        <= bcbs_pkg::S_FETCH;
			core_reg.mode      <= bcbs_pkg::M_DIR;
			core_reg.pc        <= bcbs_pkg::PC_RESET;
			core_reg.sp        <= bcbs_pkg::SP_RESET;
			core_reg.bus.addr  <= bcbs_pkg::PC_RESET;
			core_reg.bus.rw    <= 1'b1;
		end
		else
		begin
			core_reg <= core_next;
		end
	end

	assign o_bus     = core_reg.bus;
	assign o_prdata  = core_reg.prdata;
	assign o_pready  = core_reg.pready;
	assign o_pslverr = core_reg.pslverr;
	assign o_e_tick  = e_tick;

	// ****************************************
	// checks
	// ****************************************
	sequence s_push_lo_end;
		e_tick && core_reg.st == bcbs_pkg::S_PUSH_LO;
	endsequence

	sequence s_push_hi_end;
		e_tick && core_reg.st == bcbs_pkg::S_PUSH_HI;
	endsequence

	a_setbits_length: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		core_reg.st == bcbs_pkg::S_WRITE |->
		core_reg.cyc == ((core_reg.mode == bcbs_pkg::M_DIR) ? 4'h5 :
			(core_reg.mode == bcbs_pkg::M_IDX_X) ? 4'h6 : 4'h7))
		else $error("set-bits write in wrong cycle");

	a_setbits_write: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		core_reg.st == bcbs_pkg::S_WRITE |->
		!o_bus.rw && o_bus.addr == core_reg.ea && o_bus.wdata == (core_reg.oper | core_reg.mask))
		else $error("set-bits write-back wrong");

	a_mask_dummy_addr: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(e_tick && core_reg.st == bcbs_pkg::S_MASK) |=>
		o_bus.addr == bcbs_pkg::DUMMY_ADDR && o_bus.rw)
		else $error("set-bits dummy cycle not at FFFF");

	a_return_addr: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		core_reg.st == bcbs_pkg::S_PUSH_LO |->
		core_reg.pc == core_reg.op_addr + 16'h0002 && o_bus.wdata == core_reg.pc[7:0])
		else $error("return address not opcode plus two");

	a_push_low_sp: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		s_push_lo_end |=> core_reg.sp == $past(core_reg.sp) - 16'h0001 &&
		o_bus.addr == core_reg.sp && o_bus.wdata == core_reg.pc[15:8])
		else $error("low push did not step stack pointer");

	a_push_high_sp: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		s_push_hi_end |=> core_reg.sp == $past(core_reg.sp) - 16'h0001)
		else $error("high push did not step stack pointer");

	a_call_target: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		s_push_hi_end |=> core_reg.pc == core_reg.op_addr + 16'h0002 + sext(core_reg.off))
		else $error("call target wrong");

	a_call_length: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		core_reg.st == bcbs_pkg::S_PUSH_HI |-> core_reg.cyc == 4'h5 && !o_bus.rw)
		else $error("call high push not in sixth cycle");

	a_no_ovf_branch: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(e_tick && core_reg.st == bcbs_pkg::S_BR_DUMMY &&
		core_reg.opcode == bcbs_pkg::OP_BR_NO_OVF) |=>
		core_reg.pc == ($past(core_reg.flags[bcbs_pkg::FLAG_V]) ? $past(core_reg.pc) :
			$past(core_reg.pc) + sext(core_reg.off)))
		else $error("no-overflow branch decision wrong");

	a_branch_three: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		core_reg.st == bcbs_pkg::S_BR_DUMMY |->
		core_reg.cyc == 4'h2 && o_bus.addr == bcbs_pkg::DUMMY_ADDR && o_bus.rw)
		else $error("branch dummy cycle wrong");

	a_signed_cond: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(core_reg.st == bcbs_pkg::S_BR_DUMMY && core_reg.opcode == 8'h2E) |->
		cond_taken == !(core_reg.flags[bcbs_pkg::FLAG_Z] |
			(core_reg.flags[bcbs_pkg::FLAG_N] ^ core_reg.flags[bcbs_pkg::FLAG_V])))
		else $error("signed greater decision wrong");

endmodule

// ---- verification/bcbs_mem_model.sv ----
// system bus memory model that keeps a trace of every bus cycle
`timescale 1ns/1ps
module bcbs_mem_model (
	// clock and bus
	input  wire logic                i_core_clk,
	input  wire bcbs_pkg::bcbs_bus_t i_bus,
	input  wire logic                i_e_tick,
	// read data
	output logic      [7:0]          o_rdata
);
	logic [7:0]  mem [0:65535];
	logic [24:0] trace [$];
	logic [7:0]  last;
	// ****
	// idle bus shows the inverted last byte, so a stale read never matches by luck
	// ****
	initial
	begin
		foreach (mem[i])
			mem[i] = 8'h01;
		last = 8'h00;
	end
	assign o_rdata = (i_bus.valid && i_bus.rw) ? mem[i_bus.addr] : ~last;
	always @(posedge i_core_clk)
	begin
		if (i_e_tick && i_bus.valid)
		begin
			trace.push_back({i_bus.rw, i_bus.addr, i_bus.rw ? 8'h00 : i_bus.wdata});
			if (i_bus.rw)
				last <= mem[i_bus.addr];
			else
				mem[i_bus.addr] <= i_bus.wdata;
		end
	end
endmodule

// ---- verification/test_bitset_call_branch_sequencer.sv ----
// self-checking bench of the bit-set, call and branch sequencer
`timescale 1ns/1ps
module test_bitset_call_branch_sequencer;
	logic                clk;
	logic                rst;
	logic                psel;
	logic                penable;
	logic                pwrite;
	logic [7:0]          paddr;
	logic [31:0]         pwdata;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	bcbs_pkg::bcbs_bus_t bus;
	logic [7:0]          rdata;
	logic                tick;
	int                  miscompares = 0;
	int                  n_checks = 0;
	int                  cycles = 0;
	logic [31:0]         rd;
	logic                err;
	logic [15:0]         tgt;
	// branch rows: opcode, flags, zero, taken
	logic [15:0]         rows [32] = '{
		16'h2001, 16'h20F1, 16'h2100, 16'h21F0, 16'h2201, 16'h2240, 16'h2311, 16'h2300,
		16'h2401, 16'h2410, 16'h2511, 16'h25E0, 16'h26B1, 16'h2640, 16'h2741, 16'h2700,
		16'h28D1, 16'h2820, 16'h2921, 16'h2900, 16'h2A71, 16'h2A80, 16'h2B81, 16'h2B00,
		16'h2CA1, 16'h2C80, 16'h2D21, 16'h2DA0, 16'h2EA1, 16'h2EE0, 16'h2FE1, 16'h2FA0
	};

	bcbs_sequencer #(
		.E_DIV (3)
	) bcbs_sequencer_inst (
		.i_core_clk  (clk),
		.i_sys_rst   (rst),
		.i_psel      (psel),
		.i_penable   (penable),
		.i_pwrite    (pwrite),
		.i_paddr     (paddr),
		.i_pwdata    (pwdata),
		.o_prdata    (prdata),
		.o_pready    (pready),
		.o_pslverr   (pslverr),
		.o_bus       (bus),
		.i_bus_rdata (rdata),
		.o_e_tick    (tick)
	);
	bcbs_mem_model bcbs_mem_model_inst (
		.i_core_clk (clk),
		.i_bus      (bus),
		.i_e_tick   (tick),
		.o_rdata    (rdata)
	);

	initial
		clk = 1'b0;
	always #20 clk = ~clk;

	// ****
	// shared tasks
	// ****
	task automatic close_out();
		$display("checks %0d, mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check_val(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask

	// request held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// program bytes, first byte at the lowest address
	task automatic load(input logic [15:0] a, input logic [31:0] b);
		for (int i = 0; i < 4; i++)
			bcbs_mem_model_inst.mem[a + 16'(i)] = b[31 - 8 * i -: 8];
	endtask

	// run from pc, stop after the listed cycles, compare the trace
	task automatic run_from(input logic [15:0] pc, input logic [24:0] exp [$]);
		bcbs_mem_model_inst.trace.delete();
		apb(1'b1, bcbs_pkg::REG_PC, {16'h0000, pc});
		apb(1'b1, bcbs_pkg::REG_CTRL, 32'h0000_0001);
		while (bcbs_mem_model_inst.trace.size() < exp.size())
			@(posedge clk);
		apb(1'b1, bcbs_pkg::REG_CTRL, 32'h0000_0000);
		apb(1'b0, bcbs_pkg::REG_STATUS, 32'h0000_0000);
		while (rd[bcbs_pkg::STAT_BUSY] !== 1'b0)
			apb(1'b0, bcbs_pkg::REG_STATUS, 32'h0000_0000);
		foreach (exp[i])
			check_val("bus cycle", {7'h00, bcbs_mem_model_inst.trace[i]}, {7'h00, exp[i]});
	endtask

	// hang guard: well above the roughly one thousand cycles the run needs
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			miscompares++;
			close_out();
		end
	end

	// ****
	// main sequence
	// ****
	initial
	begin
		rst     = 1'b1;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0000_0000;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		check_val("bus valid", {31'h0, bus.valid}, 32'h0000_0000);
		apb(1'b0, bcbs_pkg::REG_PC, 32'h0000_0000);
		check_val("pc", rd, 32'h0000_0000);
		apb(1'b0, bcbs_pkg::REG_SP, 32'h0000_0000);
		check_val("sp", rd, 32'h0000_00FF);
		apb(1'b1, bcbs_pkg::REG_STATUS, 32'hFFFF_FFFF);
		apb(1'b0, bcbs_pkg::REG_STATUS, 32'h0000_0000);
		check_val("status", rd, 32'h0000_0000);
		apb(1'b0, 8'h40, 32'h0000_0000);
		check_val("unmapped err", {31'h0, err}, 32'h0000_0001);
		check_val("unmapped data", rd, 32'h0000_0000);
		apb(1'b1, bcbs_pkg::REG_SP, 32'h0000_01FF);
		// negative offset reaches back below the instruction
		foreach (rows[i])
		begin
			load(16'h0100, {rows[i][15:8], 24'hF0_0101});
			apb(1'b1, bcbs_pkg::REG_FLAGS, {28'h0, rows[i][7:4]});
			tgt = rows[i][0] ? 16'h00F2 : 16'h0102;
			run_from(16'h0100, '{25'h1_0100_00, 25'h1_0101_00, 25'h1_FFFF_00, {1'b1, tgt, 8'h00}});
		end
		// ****
		// bit-set in all three modes, then the call
		// ****
		load(16'h0200, 32'h1440_8101);
		bcbs_mem_model_inst.mem[16'h0040] = 8'h12;
		run_from(16'h0200, '{25'h1_0200_00, 25'h1_0201_00, 25'h1_0040_00, 25'h1_0202_00,
			25'h1_FFFF_00, 25'h0_0040_93, 25'h1_0203_00});
		apb(1'b1, bcbs_pkg::REG_IX, 32'h0000_1000);
		load(16'h0300, 32'h1C05_0F01);
		bcbs_mem_model_inst.mem[16'h1005] = 8'hA0;
		run_from(16'h0300, '{25'h1_0300_00, 25'h1_0301_00, 25'h1_FFFF_00, 25'h1_1005_00,
			25'h1_0302_00, 25'h1_FFFF_00, 25'h0_1005_AF, 25'h1_0303_00});
		apb(1'b1, bcbs_pkg::REG_IY, 32'h0000_20F0);
		load(16'h0400, 32'h181C_FE42);
		run_from(16'h0400, '{25'h1_0400_00, 25'h1_0401_00, 25'h1_0402_00, 25'h1_FFFF_00,
			25'h1_21EE_00, 25'h1_0403_00, 25'h1_FFFF_00, 25'h0_21EE_43,
			25'h1_0404_00});
		// return address carries into the high byte
		load(16'h05FE, 32'h8D7F_0101);
		run_from(16'h05FE, '{25'h1_05FE_00, 25'h1_05FF_00, 25'h1_FFFF_00, 25'h1_067F_00,
			25'h0_01FF_00, 25'h0_01FE_06, 25'h1_067F_00});
		apb(1'b0, bcbs_pkg::REG_SP, 32'h0000_0000);
		check_val("sp after call", rd, 32'h0000_01FD);
		// the target holds filler opcode 01: not taken, flagged unsupported
		apb(1'b0, bcbs_pkg::REG_STATUS, 32'h0000_0000);
		check_val("status after call", rd, 32'h0000_0104);
		close_out();
	end
endmodule
